// file: include/tsp_params.svh
// Purpose: constants of the shared timer/io port: register indices, resets, bus codes
// Assumes: byte address of a register is four times its index
// Notes: included by bare name
`ifndef TSP_PARAMS_SVH
`define TSP_PARAMS_SVH

`define TSP_PORT_WIDTH 8
`define TSP_DIR_INDEX 16'hfe88
`define TSP_DATA_INDEX 16'hfe8a
`define TSP_DIR_RESET 8'h00
`define TSP_DATA_RESET 8'h00
`define TSP_DIR_READBACK 8'hff
`define TSP_UNMAPPED_READ 32'h00000000
`define TSP_HTRANS_NONSEQ_BIT 1
`define TSP_HRESP_OKAY 1'b0

`endif

// file: include/tsp_pkg.sv
// Purpose: types of the shared timer/io port
// Assumes: eight pins
// Notes: constants live in tsp_params.svh
package tsp_pkg;

  typedef struct packed {
    logic [7:0] oc_en;
    logic [7:0] oc_level;
  } tsp_tmr_in_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } tsp_pin_out_t;

  typedef enum logic [2:0] {
    TSP_PH_IDLE = 3'b001,
    TSP_PH_WDIR = 3'b010,
    TSP_PH_WDATA = 3'b100
  } tsp_phase_t;

endpackage

// file: hw/tsp_port.sv
// Purpose: eight-bit io port shared with timer capture/compare pins, AHB-Lite registers
// Assumes: timer and standby controls come from logic on SYS_CLK; pins are asynchronous
// Notes: zero-wait-state slave; pin outputs change on the same edge as the register write they follow
//   sensed pin levels reach reads and the timer three cycles late, through the synchroniser and an output register
//   writes are forwarded in their data phase, so a read right behind one sees the new value
//   HSIZE is ignored: every access moves the low byte lane of one whole word
//   no wait states are inserted, so HREADY from other slaves only freezes the phase logic and the read data
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "tsp_params.svh"

module tsp_port #(
  parameter int WIDTH = `TSP_PORT_WIDTH
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // standby controls
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // timer pulse unit
  input wire tsp_pkg::tsp_tmr_in_t TMR_IN,
  output logic [7:0] TMR_CAPTURE_IN,
  // port pins
  input wire logic [7:0] PIN_IN,
  output tsp_pkg::tsp_pin_out_t PIN_OUT
);
  import tsp_pkg::*;

  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  // registers and bus state
  logic [7:0] dir_reg;
  logic [7:0] data_reg;
  logic [7:0] dir_next;
  logic [7:0] data_next;
  logic dir_we;
  logic data_we;
  tsp_phase_t phase_reg;
  tsp_phase_t phase_next;

  // pin sampling
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;

  // combinational
  logic addr_take;
  logic hit_dir;
  logic hit_data;
  logic [7:0] oc_live;
  logic [7:0] data_wr;
  logic [7:0] data_view;
  logic [31:0] rdata_next;
  logic [7:0] dir_wr;
  logic [7:0] oe_next;
  logic [7:0] level_next;
  logic [7:0] cap_next;
  logic read_dir;
  logic read_data;

  // byte address of a register from its index
  function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] index);
    reg_hit = (addr == {14'h0000, index, 2'h0});
  endfunction

  // value read from the data register for one set of direction/compare/stored/sensed bits
  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] oc,
                                           input logic [7:0] stored,
                                           input logic [7:0] sensed);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (oc[i]) begin
        v[i] = sensed[i];
      end else if (dir[i]) begin
        v[i] = stored[i];
      end else begin
        v[i] = sensed[i];
      end
    end
    port_view = v;
  endfunction

  // drive enable per pin: compare ownership overrides the direction bit
  function automatic logic [7:0] drive_enable(input logic [7:0] dir, input logic [7:0] oc);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (oc[i]) begin
        e[i] = 1'b1;
      end else begin
        e[i] = dir[i];
      end
    end
    drive_enable = e;
  endfunction

  // drive level per pin: the stored bit has no say on a compare pin
  function automatic logic [7:0] drive_level(input logic [7:0] oc, input logic [7:0] tmr_level,
                                             input logic [7:0] stored);
    logic [7:0] l;
    l = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (oc[i]) begin
        l[i] = tmr_level[i];
      end else begin
        l[i] = stored[i];
      end
    end
    drive_level = l;
  endfunction

  // capture feed per pin: a driven capture pin hands the timer its own output value
  function automatic logic [7:0] capture_view(input logic [7:0] dir, input logic [7:0] oc,
                                              input logic [7:0] stored,
                                              input logic [7:0] sensed);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (dir[i] && !oc[i]) begin
        c[i] = stored[i];
      end else begin
        c[i] = sensed[i];
      end
    end
    capture_view = c;
  endfunction

  // a register byte on the low lane of the read bus; upper lanes read as zero
  function automatic logic [31:0] lane_word(input logic [7:0] b);
    lane_word = {24'h000000, b};
  endfunction

  // reset: asserted at once, released through two flops
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // pins arrive from outside; two flops before anything reads them
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else begin
      pin_meta_reg <= PIN_IN;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // software standby resets the timer, so compare ownership is dropped
  always_comb begin
    oc_live = SW_STANDBY ? 8'h00 : TMR_IN.oc_en;
  end

  // address phase decode
  always_comb begin
    addr_take = HSEL && HREADY && HTRANS[`TSP_HTRANS_NONSEQ_BIT];
    hit_dir = reg_hit(HADDR, `TSP_DIR_INDEX);
    hit_data = reg_hit(HADDR, `TSP_DATA_INDEX);
  end

  always_comb begin
    phase_next = TSP_PH_IDLE;
    if (addr_take && HWRITE && hit_dir) begin
      phase_next = TSP_PH_WDIR;
    end else if (addr_take && HWRITE && hit_data) begin
      phase_next = TSP_PH_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      phase_reg <= TSP_PH_IDLE;
    end else if (HW_STANDBY) begin
      phase_reg <= TSP_PH_IDLE;
    end else if (HREADY) begin
      phase_reg <= phase_next;
    end
  end

  // one-hot phase turned into the write strobes of the data phase
  always_comb begin
    dir_we = 1'b0;
    data_we = 1'b0;
    unique case (phase_reg)
      TSP_PH_IDLE: begin
        dir_we = 1'b0;
        data_we = 1'b0;
      end
      TSP_PH_WDIR: begin
        dir_we = 1'b1;
      end
      TSP_PH_WDATA: begin
        data_we = 1'b1;
      end
    endcase
  end

  // a write in its data phase is seen by a read right behind it and by the pins
  always_comb begin
    dir_wr = dir_we ? HWDATA[7:0] : dir_reg;
    data_wr = data_we ? HWDATA[7:0] : data_reg;
    data_view = port_view(dir_wr, oc_live, data_wr, pin_sync_reg);
    oe_next = drive_enable(dir_wr, oc_live);
    level_next = drive_level(oc_live, TMR_IN.oc_level, data_wr);
    cap_next = capture_view(dir_wr, oc_live, data_wr, pin_sync_reg);
  end

  // direction next value: hardware standby clears it, software standby keeps it
  always_comb begin
    dir_next = dir_reg;
    if (HW_STANDBY) begin
      dir_next = `TSP_DIR_RESET;
    end else if (dir_we) begin
      dir_next = HWDATA[7:0];
    end
  end

  // data next value: stored whatever the direction or timer use of the pin
  always_comb begin
    data_next = data_reg;
    if (HW_STANDBY) begin
      data_next = `TSP_DATA_RESET;
    end else if (data_we) begin
      data_next = HWDATA[7:0];
    end
  end

  // write-only direction bits, written from the low byte lane
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dir_reg <= `TSP_DIR_RESET;
    end else begin
      dir_reg <= dir_next;
    end
  end

  // data bits are stored whatever the direction or timer use
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      data_reg <= `TSP_DATA_RESET;
    end else begin
      data_reg <= data_next;
    end
  end

  // read requests taken in this address phase
  always_comb begin
    read_dir = addr_take && !HWRITE && hit_dir;
    read_data = addr_take && !HWRITE && hit_data;
  end

  // read data is prepared in the address phase so it stands in the data phase
  always_comb begin
    rdata_next = `TSP_UNMAPPED_READ;
    if (read_dir) begin
      rdata_next = lane_word(`TSP_DIR_READBACK);
    end else if (read_data) begin
      rdata_next = lane_word(data_view);
    end
  end

  // read data holds while another slave stretches the bus
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      HRDATA <= `TSP_UNMAPPED_READ;
    end else if (HREADY) begin
      HRDATA <= rdata_next;
    end
  end

  // never stalls: every transfer completes with zero wait states
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      HREADYOUT <= 1'b1;
    end else begin
      HREADYOUT <= 1'b1;
    end
  end

  // never errors; unmapped reads give zero, unmapped writes vanish
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      HRESP <= `TSP_HRESP_OKAY;
    end else begin
      HRESP <= `TSP_HRESP_OKAY;
    end
  end

  // pin drivers; compare wins over the direction bit, capture leaves it in force
  // registered, so a decode hazard never glitches a pin
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      PIN_OUT.level <= 8'h00;
      PIN_OUT.oe <= 8'h00;
    end else begin
      PIN_OUT.level <= level_next;
      PIN_OUT.oe <= oe_next;
    end
  end

  // capture input: driven data on direction-output pins, sensed level on input and compare pins
  // it follows the same forwarded values as the pins, so on driven pins outside compare use the two never disagree
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      TMR_CAPTURE_IN <= 8'h00;
    end else begin
      TMR_CAPTURE_IN <= cap_next;
    end
  end

endmodule

// file: tb/tsp_port_monitor.sv
// Purpose: port-level checks of the shared timer/io port
// Assumes: internal reset frees outputs two edges after NRST rises
// Notes: bound to tsp_port below
`timescale 1ns/10ps
`include "tsp_params.svh"
module tsp_port_monitor (
  // clock, reset, standby
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  // timer and pins
  input wire tsp_pkg::tsp_tmr_in_t TMR_IN,
  input wire logic [7:0] TMR_CAPTURE_IN,
  input wire logic [7:0] PIN_IN,
  input wire tsp_pkg::tsp_pin_out_t PIN_OUT
);
  import tsp_pkg::*;
  localparam logic [31:0] DIR_A = {14'h0, `TSP_DIR_INDEX, 2'b00};
  localparam logic [31:0] DAT_A = {14'h0, `TSP_DATA_INDEX, 2'b00};
  logic [1:0] up_reg;
  logic live;
  logic [7:0] oc;
  assign live = (up_reg == 2'h3);
  assign oc = TMR_IN.oc_en & ~{8{SW_STANDBY}};
  // outputs stay in reset for a while after NRST rises, so wait for saturation
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      up_reg <= 2'h0;
    end else if (!live) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  sequence rd_s(a); HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == a; endsequence
  dir_read_a: assert property (rd_s(DIR_A) |=> HRDATA == {24'h0, `TSP_DIR_READBACK})
    else $error("direction read wrong");
  data_read_a: assert property (rd_s(DAT_A) |=> HRDATA[31:8] == 24'h0 &&
    ((HRDATA[7:0] ^ PIN_OUT.level) & PIN_OUT.oe & ~$past(oc)) == 8'h0) else $error("data read");
  comp_drive_a: assert property (live |=> (PIN_OUT.oe & $past(oc)) == $past(oc))
    else $error("compare pin not driven");
  comp_level_a: assert property (live |=> ((PIN_OUT.level ^ $past(TMR_IN.oc_level)) &
    $past(oc)) == 8'h0) else $error("compare level");
  cap_feed_a: assert property (live |-> ((TMR_CAPTURE_IN ^ PIN_OUT.level) &
    PIN_OUT.oe & ~$past(oc)) == 8'h0) else $error("capture feed");
  cap_sense_a: assert property ((live && $stable(PIN_IN)) [*4] |->
    ((TMR_CAPTURE_IN ^ PIN_IN) & ~PIN_OUT.oe) == 8'h0) else $error("capture sense");
  stby_mask_a: assert property (live && SW_STANDBY |=>
    ((TMR_CAPTURE_IN ^ PIN_OUT.level) & PIN_OUT.oe) == 8'h0) else $error("standby mask");
  hw_clear_a: assert property ((live && HW_STANDBY) [*3] |->
    ((PIN_OUT.oe | PIN_OUT.level) & ~$past(oc)) == 8'h0) else $error("standby clear");
endmodule
bind tsp_port tsp_port_monitor MON (.SYS_CLK, .NRST, .HW_STANDBY, .SW_STANDBY, .HSEL, .HADDR,
  .HTRANS, .HWRITE, .HREADY, .HRDATA, .TMR_IN, .TMR_CAPTURE_IN, .PIN_IN, .PIN_OUT);

// file: tb/tsp_pin_model.sv
// Purpose: outside world of the port pins
// Assumes: no pull resistors; an undriven pin shows the outside level
// Notes: combinational
`timescale 1ns/10ps
module tsp_pin_model (
  // design side
  input wire tsp_pkg::tsp_pin_out_t pin_out,
  // outside level and sensed level
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  import tsp_pkg::*;
  // a driven pin shows the drive
  assign pin_in = (pin_out.oe & pin_out.level) | (~pin_out.oe & ext_level);
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench of the shared timer/io port
// Assumes: zero-wait-state slave; pin levels settle within four cycles
// Notes: the bench plays the timer unit
`timescale 1ns/10ps
`include "tsp_params.svh"
module tb_top;
  import tsp_pkg::*;
  localparam logic [31:0] DIR_A = {14'h0, `TSP_DIR_INDEX, 2'b00};
  localparam logic [31:0] DAT_A = {14'h0, `TSP_DATA_INDEX, 2'b00};
  logic clk = 1'b0, rst_n = 1'b0, hw_sb = 1'b0, sw_sb = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hready, hresp;
  logic [7:0] cap, pin_in, ext = 8'h0;
  tsp_tmr_in_t tmr = '0;
  tsp_pin_out_t po;
  int bad_count = 0, total_checks = 0;
  always #2 clk = ~clk;
  tsp_port DUT (.SYS_CLK(clk), .NRST(rst_n), .HW_STANDBY(hw_sb), .SW_STANDBY(sw_sb),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
    .TMR_IN(tmr), .TMR_CAPTURE_IN(cap), .PIN_IN(pin_in), .PIN_OUT(po));
  tsp_pin_model PINS (.pin_out(po), .ext_level(ext), .pin_in(pin_in));
  task conclude;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // undriven pins carry no meaning, so only driven levels are compared
  function logic [31:0] drv();
    return {16'h0, po.level & po.oe, po.oe};
  endfunction
  task xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    cyc(3);
    chk("reset pins", 32'h0, drv());
    ext <= 8'h5a;
    cyc(4);
    xfer(DAT_A, 1'b0, 8'h0);
    chk("input read", 32'h5a, rd);
    chk("ready", 32'h1, {31'h0, hready});
    chk("response", {31'h0, `TSP_HRESP_OKAY}, {31'h0, hresp});
    xfer(DAT_A, 1'b1, 8'hc3);
    cyc(1);
    chk("input drive", 32'h0, drv());
    xfer(DIR_A, 1'b1, 8'h0f);
    cyc(4);
    xfer(DIR_A, 1'b0, 8'h0);
    chk("dir read", 32'hff, rd);
    xfer(DAT_A, 1'b0, 8'h0);
    chk("mixed read", 32'h53, rd);
    chk("mixed pins", 32'h030f, drv());
    chk("capture", 32'h53, {24'h0, cap});
    tmr <= {8'h81, 8'h80};
    cyc(4);
    chk("compare pins", 32'h828f, drv());
    xfer(DAT_A, 1'b0, 8'h0);
    chk("compare read", 32'hd2, rd);
    sw_sb <= 1'b1;
    cyc(4);
    chk("standby pins", 32'h030f, drv());
    xfer(DAT_A, 1'b0, 8'h0);
    chk("standby read", 32'h53, rd);
    sw_sb <= 1'b0;
    tmr <= '0;
    hw_sb <= 1'b1;
    cyc(3);
    hw_sb <= 1'b0;
    cyc(1);
    chk("hw clear", 32'h0, drv());
    xfer(DIR_A, 1'b1, 8'hff);
    xfer(DAT_A, 1'b0, 8'h0);
    chk("data clear", 32'h0, rd);
    chk("capture out", 32'h0, {24'h0, cap});
    xfer(DAT_A + 32'h4, 1'b0, 8'h0);
    chk("unmapped", 32'h0, rd);
    conclude;
  end
  initial begin
    cyc(2000);
    bad_count++;
    conclude;
  end
endmodule
